// [core/cwg_defs.vh]
// Register offsets, field positions and reset values of the waveform generator
`ifndef CWG_DEFS_VH
`define CWG_DEFS_VH

// Byte offsets on the register bus
`define CWG_OFF_CTRL      6'h00
`define CWG_OFF_SOURCE    6'h04
`define CWG_OFF_RISE_GAP  6'h08
`define CWG_OFF_FALL_GAP  6'h0c
`define CWG_OFF_OVERRIDE  6'h10
`define CWG_OFF_STATUS    6'h14

// Control register fields
`define CWG_CTRL_ON       7
`define CWG_CTRL_B_ALLOW  6
`define CWG_CTRL_A_ALLOW  5
`define CWG_CTRL_B_SENSE  4
`define CWG_CTRL_A_SENSE  3
`define CWG_CTRL_CLK_PICK 0

// Override register fields
`define CWG_OVR_EN        0
`define CWG_OVR_A_LEVEL   1
`define CWG_OVR_B_LEVEL   2

// Status register fields
`define CWG_ST_A_DRIVE    0
`define CWG_ST_B_DRIVE    1
`define CWG_ST_INPUT      2
`define CWG_ST_RISE_BUSY  3
`define CWG_ST_FALL_BUSY  4

// Reset values
`define CWG_CTRL_RST      8'h00
`define CWG_SOURCE_RST    3'h0
`define CWG_GAP_RST       6'h00
`define CWG_OVR_RST       3'h0

// Source codes
`define CWG_SRC_PWM1      3'h0
`define CWG_SRC_PWM2      3'h1
`define CWG_SRC_PWM3      3'h2
`define CWG_SRC_PWM4      3'h3
`define CWG_SRC_ACCUM     3'h4
`define CWG_SRC_LOGIC     3'h5

// Gap clock choice
`define CWG_CLK_SYSTEM    1'b0
`define CWG_CLK_FAST_OSC  1'b1

// Nominal rate of the internal fast oscillator in MHz
`define CWG_FAST_OSC_MHZ  16

`endif

// [core/cwg_gap_counter.v]
// Dead-band gap counter: counts gap clock ticks from zero up to a setting
`timescale 1ns/1ps
module cwg_gap_counter #(
   parameter GAP_W = 6
) (
   input  wire             clock_in,
   input  wire             rst_n_in,
   input  wire             start_in,
   input  wire             abort_in,
   input  wire             tick_in,
   input  wire [GAP_W-1:0] setting_in,
   output wire             done_out,
   output wire             busy_out
);

   reg              busy_reg;
   reg  [GAP_W-1:0] count_reg;
   wire [GAP_W-1:0] count_inc;
   wire             zero_gap;
   wire             reached;

   // Count of ticks seen so far plus the one arriving now
   assign count_inc = count_reg + {{(GAP_W-1){1'b0}}, 1'b1};
   assign zero_gap  = (setting_in == {GAP_W{1'b0}});
   assign reached   = busy_reg & tick_in & (count_inc == setting_in);

   // Zero setting finishes at once, no counted delay
   assign done_out = (start_in & zero_gap) | (reached & ~abort_in & ~start_in);
   assign busy_out = busy_reg;

   // Counter state; abort drops a pending gap
   always @(posedge clock_in) begin
      if (!rst_n_in) begin
         busy_reg  <= 1'b0;
         count_reg <= {GAP_W{1'b0}};
      end else if (start_in) begin
         busy_reg  <= ~zero_gap;
         count_reg <= {GAP_W{1'b0}};
      end else if (abort_in || reached) begin
         busy_reg  <= 1'b0;
         count_reg <= {GAP_W{1'b0}};
      end else if (busy_reg && tick_in) begin
         count_reg <= count_inc;
      end
   end

endmodule

// [core/cwg_top.v]
// Complementary waveform generator with dead band and Avalon-MM registers
//
// The placing of the registers and register access over Avalon-MM are this design's own decisions.
`timescale 1ns/1ps
`include "cwg_defs.vh"

module cwg_top #(
   parameter GAP_W  = 6,
   parameter N_SRC  = 6,
   parameter ADDR_W = 6
) (
   input  wire              clock_in,
   input  wire              rst_n_in,
   // Avalon-MM slave
   input  wire [ADDR_W-1:0] avs_address_in,
   input  wire              avs_read_in,
   input  wire              avs_write_in,
   input  wire [31:0]       avs_writedata_in,
   input  wire [3:0]        avs_byteenable_in,
   output reg  [31:0]       avs_readdata_out,
   output wire              avs_waitrequest_out,
   // Candidate sources and oscillator
   input  wire              pwm_one_wave_in,
   input  wire              pwm_two_wave_in,
   input  wire              pwm_three_wave_in,
   input  wire              pwm_four_wave_in,
   input  wire              accum_osc_wave_in,
   input  wire              logic_cell_one_wave_in,
   input  wire              internal_fast_osc_in,
   // Pin drives
   output reg               primary_out,
   output reg               primary_oe_out,
   output reg               complement_out,
   output reg               complement_oe_out
);

   ////////////////////////////////////////////////////////////////////////////
   // Declarations

   reg  [7:0]       ctrl_reg;
   reg  [2:0]       source_pick_reg;
   reg  [GAP_W-1:0] rise_gap_setting_reg;
   reg  [GAP_W-1:0] fall_gap_setting_reg;
   reg  [2:0]       override_reg;
   reg              ack_reg;
   reg  [N_SRC-1:0] src_meta_reg;
   reg  [N_SRC-1:0] src_sync_reg;
   reg              osc_meta_reg;
   reg              osc_sync_reg;
   reg              osc_prev_reg;
   reg              in_prev_reg;
   reg              on_prev_reg;
   reg              drive_a_reg;
   reg              drive_b_reg;
   reg  [31:0]      read_next;
   reg              sel_wave;

   wire [N_SRC-1:0] src_raw;
   wire             module_on;
   wire             primary_pin_allow;
   wire             complement_pin_allow;
   wire             primary_sense;
   wire             complement_sense;
   wire             gap_clock_pick;
   wire             request;
   wire             wr_take;
   wire             gap_tick;
   wire             rise_edge;
   wire             fall_edge;
   wire             rise_done;
   wire             fall_done;
   wire             rise_busy;
   wire             fall_busy;
   wire             wave_a;
   wire             wave_b;

   ////////////////////////////////////////////////////////////////////////////
   // Helpers

   // Lane-merged write of the low byte only; upper lanes have no storage
   function [7:0] merge_byte;
      input [7:0]  old_val;
      input [31:0] wdata;
      input [3:0]  be;
      begin
         merge_byte = be[0] ? wdata[7:0] : old_val;
      end
   endfunction

   // Source mux; reserved codes give a quiet low input
   function pick_source;
      input [2:0]       code;
      input [N_SRC-1:0] waves;
      begin
         case (code)
            `CWG_SRC_PWM1:  pick_source = waves[0];
            `CWG_SRC_PWM2:  pick_source = waves[1];
            `CWG_SRC_PWM3:  pick_source = waves[2];
            `CWG_SRC_PWM4:  pick_source = waves[3];
            `CWG_SRC_ACCUM: pick_source = waves[4];
            `CWG_SRC_LOGIC: pick_source = waves[5];
            default:        pick_source = 1'b0;
         endcase
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Field aliases

   assign module_on            = ctrl_reg[`CWG_CTRL_ON];
   assign complement_pin_allow = ctrl_reg[`CWG_CTRL_B_ALLOW];
   assign primary_pin_allow    = ctrl_reg[`CWG_CTRL_A_ALLOW];
   assign complement_sense     = ctrl_reg[`CWG_CTRL_B_SENSE];
   assign primary_sense        = ctrl_reg[`CWG_CTRL_A_SENSE];
   assign gap_clock_pick       = ctrl_reg[`CWG_CTRL_CLK_PICK];

   ////////////////////////////////////////////////////////////////////////////
   // Bus slave

   // One wait cycle per access: read data is settled before release
   assign request             = avs_read_in | avs_write_in;
   assign avs_waitrequest_out = request & ~ack_reg;
   assign wr_take             = avs_write_in & ack_reg;   // Lands at the release edge

   // Acknowledge pulses once per held request
   always @(posedge clock_in) begin
      if (!rst_n_in) begin
         ack_reg <= 1'b0;
      end else begin
         ack_reg <= request & ~ack_reg;
      end
   end

   // Writable registers; unmapped and status writes are ignored
   always @(posedge clock_in) begin
      if (!rst_n_in) begin
         ctrl_reg             <= `CWG_CTRL_RST;
         source_pick_reg      <= `CWG_SOURCE_RST;
         rise_gap_setting_reg <= `CWG_GAP_RST;
         fall_gap_setting_reg <= `CWG_GAP_RST;
         override_reg         <= `CWG_OVR_RST;
      end else if (wr_take) begin
         case (avs_address_in)
            `CWG_OFF_CTRL: begin
               ctrl_reg <= merge_byte(ctrl_reg, avs_writedata_in, avs_byteenable_in) & 8'hf9;
            end
            `CWG_OFF_SOURCE: begin
               if (avs_byteenable_in[0]) begin
                  source_pick_reg <= avs_writedata_in[2:0];
               end
            end
            `CWG_OFF_RISE_GAP: begin
               if (avs_byteenable_in[0]) begin
                  rise_gap_setting_reg <= avs_writedata_in[GAP_W-1:0];
               end
            end
            `CWG_OFF_FALL_GAP: begin
               if (avs_byteenable_in[0]) begin
                  fall_gap_setting_reg <= avs_writedata_in[GAP_W-1:0];
               end
            end
            `CWG_OFF_OVERRIDE: begin
               if (avs_byteenable_in[0]) begin
                  override_reg <= avs_writedata_in[2:0];
               end
            end
            default: begin
            end
         endcase
      end
   end

   // Read mux; reserved bits and unmapped words read zero
   always @* begin
      read_next = 32'h0000_0000;
      case (avs_address_in)
         `CWG_OFF_CTRL:     read_next[7:0] = ctrl_reg;
         `CWG_OFF_SOURCE:   read_next[2:0] = source_pick_reg;
         `CWG_OFF_RISE_GAP: read_next[GAP_W-1:0] = rise_gap_setting_reg;
         `CWG_OFF_FALL_GAP: read_next[GAP_W-1:0] = fall_gap_setting_reg;
         `CWG_OFF_OVERRIDE: read_next[2:0] = override_reg;
         `CWG_OFF_STATUS: begin
            read_next[`CWG_ST_A_DRIVE]   = drive_a_reg;
            read_next[`CWG_ST_B_DRIVE]   = drive_b_reg;
            read_next[`CWG_ST_INPUT]     = in_prev_reg;
            read_next[`CWG_ST_RISE_BUSY] = rise_busy;
            read_next[`CWG_ST_FALL_BUSY] = fall_busy;
         end
         default: read_next = 32'h0000_0000;
      endcase
   end

   // Read data captured in the wait cycle, stands at the release edge
   always @(posedge clock_in) begin
      if (!rst_n_in) begin
         avs_readdata_out <= 32'h0000_0000;
      end else if (avs_read_in && !ack_reg) begin
         avs_readdata_out <= read_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Input synchronisers

   assign src_raw = {logic_cell_one_wave_in, accum_osc_wave_in, pwm_four_wave_in,
                     pwm_three_wave_in, pwm_two_wave_in, pwm_one_wave_in};

   // Every candidate is synchronised, so a source change never
   // feeds a metastable level into the edge detector
   genvar gi;
   generate
      for (gi = 0; gi < N_SRC; gi = gi + 1) begin : g_sync
         always @(posedge clock_in) begin
            if (!rst_n_in) begin
               src_meta_reg[gi] <= 1'b0;
               src_sync_reg[gi] <= 1'b0;
            end else begin
               src_meta_reg[gi] <= src_raw[gi];
               src_sync_reg[gi] <= src_meta_reg[gi];
            end
         end
      end
   endgenerate

   // Oscillator sampled as a level; its rising edge becomes a gap tick
   always @(posedge clock_in) begin
      if (!rst_n_in) begin
         osc_meta_reg <= 1'b0;
         osc_sync_reg <= 1'b0;
         osc_prev_reg <= 1'b0;
      end else begin
         osc_meta_reg <= internal_fast_osc_in;
         osc_sync_reg <= osc_meta_reg;
         osc_prev_reg <= osc_sync_reg;
      end
   end

   // Gap clock choice
   assign gap_tick = (gap_clock_pick == `CWG_CLK_SYSTEM) ? 1'b1
                     : (osc_sync_reg & ~osc_prev_reg);

   ////////////////////////////////////////////////////////////////////////////
   // Edge detection

   always @* begin
      sel_wave = pick_source(source_pick_reg, src_sync_reg);
   end

   // Previous level always tracked so enabling does not fake an edge
   always @(posedge clock_in) begin
      if (!rst_n_in) begin
         in_prev_reg <= 1'b0;
         on_prev_reg <= 1'b0;
      end else begin
         in_prev_reg <= sel_wave;
         on_prev_reg <= module_on;
      end
   end

   // Counting keys off the input only, never the outputs
   assign rise_edge = module_on & on_prev_reg & sel_wave & ~in_prev_reg;
   assign fall_edge = module_on & on_prev_reg & ~sel_wave & in_prev_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Gap counters

   cwg_gap_counter #(
      .GAP_W      (GAP_W)
   ) u_rise_gap (
      .clock_in   (clock_in),
      .rst_n_in   (rst_n_in),
      .start_in   (rise_edge),
      .abort_in   (fall_edge | ~module_on),
      .tick_in    (gap_tick),
      .setting_in (rise_gap_setting_reg),
      .done_out   (rise_done),
      .busy_out   (rise_busy)
   );

   cwg_gap_counter #(
      .GAP_W      (GAP_W)
   ) u_fall_gap (
      .clock_in   (clock_in),
      .rst_n_in   (rst_n_in),
      .start_in   (fall_edge),
      .abort_in   (rise_edge | ~module_on),
      .tick_in    (gap_tick),
      .setting_in (fall_gap_setting_reg),
      .done_out   (fall_done),
      .busy_out   (fall_busy)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Active drive state

   // Both drives start cleared on enable; the off side goes at the edge
   always @(posedge clock_in) begin
      if (!rst_n_in) begin
         drive_a_reg <= 1'b0;
         drive_b_reg <= 1'b0;
      end else if (!module_on || !on_prev_reg) begin
         drive_a_reg <= 1'b0;
         drive_b_reg <= 1'b0;
      end else begin
         if (rise_edge) begin
            drive_b_reg <= 1'b0;
         end else if (fall_done) begin
            drive_b_reg <= 1'b1;
         end
         if (fall_edge) begin
            drive_a_reg <= 1'b0;
         end else if (rise_done) begin
            drive_a_reg <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pin stage

   // Sense applies to the generated wave only
   assign wave_a = primary_sense ? drive_a_reg : ~drive_a_reg;
   assign wave_b = complement_sense ? drive_b_reg : ~drive_b_reg;

   // Registered pins; override levels bypass the sense
   always @(posedge clock_in) begin
      if (!rst_n_in) begin
         primary_out       <= 1'b0;
         complement_out    <= 1'b0;
         primary_oe_out    <= 1'b0;
         complement_oe_out <= 1'b0;
      end else begin
         primary_out       <= override_reg[`CWG_OVR_EN] ? override_reg[`CWG_OVR_A_LEVEL]
                                                        : wave_a;
         complement_out    <= override_reg[`CWG_OVR_EN] ? override_reg[`CWG_OVR_B_LEVEL]
                                                        : wave_b;
         primary_oe_out    <= module_on & primary_pin_allow;
         complement_oe_out <= module_on & complement_pin_allow;
      end
   end

endmodule

// [testbench/cwg_checker_sva.sv]
// Port-level checks of the waveform generator: bus wait, pin enables, overlap, override
`timescale 1ns/1ps
module cwg_checker #(
   parameter ADDR_W = 6
) (
   input wire              clock_in,
   input wire              rst_n_in,
   input wire [ADDR_W-1:0] avs_address_in,
   input wire              avs_read_in,
   input wire              avs_write_in,
   input wire [31:0]       avs_writedata_in,
   input wire [3:0]        avs_byteenable_in,
   input wire              avs_waitrequest_out,
   input wire              primary_out,
   input wire              primary_oe_out,
   input wire              complement_out,
   input wire              complement_oe_out
);
   reg  [7:0] ctrl_reg;
   reg  [2:0] ovr_reg;
   wire       req  = avs_read_in | avs_write_in;
   wire       take = avs_write_in & ~avs_waitrequest_out & avs_byteenable_in[0];

   ////////////////////////////////////////////////////////////////////////////////
   // Shadow of control and override, updated on the same edge the design stores them
   always @(posedge clock_in) begin
      if (!rst_n_in) begin
         ctrl_reg <= 8'h00;
         ovr_reg  <= 3'h0;
      end else begin
         if (take && avs_address_in == 6'h00) ctrl_reg <= avs_writedata_in[7:0];
         if (take && avs_address_in == 6'h10) ovr_reg <= avs_writedata_in[2:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Pins lag the registers by one edge, so steadiness of the shadow gates the checks
   default clocking @(posedge clock_in); endclocking
   default disable iff (!rst_n_in);

   sequence s_steady;
      $stable(ctrl_reg) && $stable(ovr_reg);
   endsequence

   sequence s_switch_on;
      $rose(ctrl_reg[7]) && ctrl_reg[6:5] == 2'b11 && !ovr_reg[0];
   endsequence

   a_wait_first: assert property ($rose(req) |-> avs_waitrequest_out)
      else $error("no wait state on a new request");
   a_wait_one: assert property (req && avs_waitrequest_out |=> !avs_waitrequest_out)
      else $error("wait state longer than one cycle");
   a_idle_no_wait: assert property (!req |-> !avs_waitrequest_out)
      else $error("waitrequest high while idle");
   a_off_released: assert property (!ctrl_reg[7] ##1 !ctrl_reg[7] |->
      !primary_oe_out && !complement_oe_out)
      else $error("pin driven while module off");
   a_primary_allow: assert property (ctrl_reg[7] && ctrl_reg[5] ##1
      ctrl_reg[7] && ctrl_reg[5] |-> primary_oe_out)
      else $error("primary pin not driven while allowed");
   a_complement_allow: assert property ($stable(ctrl_reg[7:6]) |->
      complement_oe_out == (ctrl_reg[7] & ctrl_reg[6]))
      else $error("complement enable does not follow control");
   a_no_overlap: assert property (s_steady ##0
      (primary_oe_out && complement_oe_out && !ovr_reg[0]) |->
      !(primary_out == ctrl_reg[3] && complement_out == ctrl_reg[4]))
      else $error("both outputs active together");
   a_override_level: assert property (s_steady ##0
      (ovr_reg[0] && ctrl_reg[7] && primary_oe_out && complement_oe_out) |->
      primary_out == ovr_reg[1] && complement_out == ovr_reg[2])
      else $error("override level not on the pins");
   a_enable_cleared: assert property (s_switch_on |=>
      primary_out == !ctrl_reg[3] && complement_out == !ctrl_reg[4])
      else $error("drives not cleared after enabling");
endmodule

bind cwg_top cwg_checker #(.ADDR_W(ADDR_W)) u_chk (
   .clock_in(clock_in), .rst_n_in(rst_n_in), .avs_address_in(avs_address_in),
   .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
   .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
   .avs_waitrequest_out(avs_waitrequest_out), .primary_out(primary_out),
   .primary_oe_out(primary_oe_out), .complement_out(complement_out),
   .complement_oe_out(complement_oe_out));

// [testbench/cwg_switch_model.sv]
// Gate driver model of the two power switches behind the generator pins
`timescale 1ns/1ps
module cwg_switch_model (
   input  wire clock_in,
   input  wire rst_n_in,
   input  wire pin_a_in,
   input  wire oe_a_in,
   input  wire pin_b_in,
   input  wire oe_b_in,
   output wire a_on_out,
   output wire b_on_out,
   output reg  overlap_out
);
   // A released pin falls to the gate pull-down, so it never conducts
   assign a_on_out = oe_a_in & pin_a_in;
   assign b_on_out = oe_b_in & pin_b_in;
   // Sticky shoot-through flag
   always @(posedge clock_in) begin
      if (!rst_n_in)
         overlap_out <= 1'b0;
      else if (a_on_out && b_on_out)
         overlap_out <= 1'b1;
   end
endmodule

// [testbench/testbench.sv]
// Self-checking bench for the complementary waveform generator
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_mismatch++; \
   $display("FAIL %0t got %0h exp %0h", $time, g, e); end end
module testbench;
   reg         clock_in    = 1'b0;
   reg         rst_n_in    = 1'b0;
   reg         osc         = 1'b0;
   reg  [5:0]  addr        = 6'h00;
   reg         rd          = 1'b0;
   reg         wr          = 1'b0;
   reg  [31:0] wdata       = 32'h0;
   reg  [3:0]  be          = 4'hf;
   reg  [5:0]  src         = 6'h00;
   wire [31:0] rdata;
   wire        wait_req, pa, pa_oe, pb, pb_oe, overlap;
   integer     n_mismatch  = 0;
   integer     checks_done = 0;
   integer     k;
   reg  [31:0] q;

   cwg_top dut (.clock_in(clock_in), .rst_n_in(rst_n_in), .avs_address_in(addr),
      .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
      .avs_byteenable_in(be), .avs_readdata_out(rdata), .avs_waitrequest_out(wait_req),
      .pwm_one_wave_in(src[0]), .pwm_two_wave_in(src[1]), .pwm_three_wave_in(src[2]),
      .pwm_four_wave_in(src[3]), .accum_osc_wave_in(src[4]),
      .logic_cell_one_wave_in(src[5]), .internal_fast_osc_in(osc),
      .primary_out(pa), .primary_oe_out(pa_oe), .complement_out(pb),
      .complement_oe_out(pb_oe));
   cwg_switch_model u_sw (.clock_in(clock_in), .rst_n_in(rst_n_in), .pin_a_in(pa),
      .oe_a_in(pa_oe), .pin_b_in(pb), .oe_b_in(pb_oe), .a_on_out(), .b_on_out(),
      .overlap_out(overlap));

   ////////////////////////////////////////////////////////////////////////////////
   // System clock and a free-running 16 MHz oscillator, unrelated in phase
   initial forever #4 clock_in = ~clock_in;
   initial forever #31.25 osc = ~osc;

   task end_sim;
      begin
         if (n_mismatch == 0 && checks_done > 0)
            $display("Finished cleanly");
         else
            $display("Finished with errors");
         $finish;
      end
   endtask

   task cyc(input integer n);
      repeat (n) @(posedge clock_in);
   endtask

   // One bus access; held until waitrequest is seen low at an edge
   task bus(input w, input [5:0] a, input [7:0] d);
      integer n;
      reg     s;
      begin
         n = 0;
         s = 1'b1;
         @(posedge clock_in);
         addr <= a;
         wdata <= {24'h0, d};
         wr <= w;
         rd <= !w;
         while (s !== 1'b0) begin
            #1;
            s = wait_req;
            q = rdata;
            @(posedge clock_in);
            n = n + 1;
         end
         `CHK(n, 2) // One wait cycle, then the release edge
         wr <= 1'b0;
         rd <= 1'b0;
      end
   endtask

   // Complement on: source high, then low, with time for the longest gap
   task prime;
      begin
         cyc(1);
         src[0] <= 1'b1;
         cyc(90);
         src[0] <= 1'b0;
         cyc(90);
      end
   endtask

   // Off-going pin falls, then count cycles until the on-going pin rises
   task measure(input rise);
      integer n;
      begin
         n = 0;
         k = 0;
         while ((rise ? pb : pa) !== 1'b0 && n < 200) begin
            @(posedge clock_in);
            #1;
            n = n + 1;
         end
         while ((rise ? pa : pb) !== 1'b1 && k < 200) begin
            @(posedge clock_in);
            #1;
            k = k + 1;
         end
      end
   endtask

   task gap(input [5:0] n, input [5:0] m);
      begin
         bus(1'b1, 6'h08, {2'b00, n});
         bus(1'b1, 6'h0c, {2'b00, m});
         prime;
         #1;
         `CHK(pb, 1'b1)
         cyc(1);
         src[0] <= 1'b1;
         measure(1'b1);
         `CHK(k, n)
         cyc(1);
         src[0] <= 1'b0;
         measure(1'b0);
         `CHK(k, m)
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Watchdog: the whole sequence needs under a fifteenth of this
   initial begin
      #200000;
      n_mismatch++;
      end_sim;
   end

   initial begin
      cyc(4);
      rst_n_in <= 1'b1;
      // Reset values, unmapped place included
      for (k = 0; k < 7; k = k + 1) begin
         bus(1'b0, 6'(k * 4), 8'h00);
         `CHK(q, 32'h0)
      end
      bus(1'b1, 6'h18, 8'hff);
      bus(1'b0, 6'h18, 8'h00);
      `CHK(q, 32'h0)
      // Status is read-only; a write without lane 0 stores nothing
      bus(1'b1, 6'h14, 8'hff);
      bus(1'b0, 6'h14, 8'h00);
      `CHK(q, 32'h0)
      be <= 4'he;
      bus(1'b1, 6'h08, 8'h3f);
      be <= 4'hf;
      bus(1'b0, 6'h08, 8'h00);
      `CHK(q, 32'h0)
      // Every source code: others high must not pass, the chosen one must
      for (k = 0; k < 8; k = k + 1) begin
         bus(1'b1, 6'h04, 8'(k));
         cyc(1);
         src <= 6'h3f ^ (6'h01 << k);
         cyc(4);
         bus(1'b0, 6'h14, 8'h00);
         `CHK(q[2], 1'b0)
         if (k < 6) begin
            cyc(1);
            src <= 6'h01 << k;
            cyc(4);
            bus(1'b0, 6'h14, 8'h00);
            `CHK(q[2], 1'b1)
         end
      end
      cyc(1);
      src <= 6'h00;
      bus(1'b1, 6'h04, 8'h00);
      bus(1'b1, 6'h00, 8'hf8);
      cyc(3);
      #1;
      `CHK({pa, pb, pa_oe}, 3'b001)
      gap(6'd0, 6'd0);
      gap(6'd5, 6'd9);
      gap(6'd63, 6'd1);
      `CHK(overlap, 1'b0)
      // Input reverses before the rising gap ends
      bus(1'b1, 6'h08, 8'h14);
      prime;
      src[0] <= 1'b1;
      cyc(6);
      src[0] <= 1'b0;
      q = 0;
      repeat (60) begin
         @(posedge clock_in);
         #1;
         if (pa === 1'b1) q = 1;
      end
      `CHK({q[0], pb}, 2'b01)
      // Oscillator ticks: 4 x 62.5 ns, one tick of slack below, one tick plus sync above
      bus(1'b1, 6'h00, 8'hf9);
      bus(1'b1, 6'h08, 8'h04);
      prime;
      src[0] <= 1'b1;
      measure(1'b1);
      `CHK(k >= 23 && k <= 41, 1'b1)
      cyc(1);
      src[0] <= 1'b0;
      cyc(40);
      // Low-active outputs, then override levels that ignore sense
      bus(1'b1, 6'h00, 8'he0);
      cyc(3);
      #1;
      `CHK({pa, pb}, 2'b10)
      bus(1'b1, 6'h10, 8'h05);
      cyc(3);
      #1;
      `CHK({pa, pb}, 2'b01)
      bus(1'b1, 6'h10, 8'h00);
      bus(1'b1, 6'h00, 8'ha8);
      cyc(3);
      #1;
      `CHK({pa_oe, pb_oe}, 2'b10)
      bus(1'b1, 6'h00, 8'h78);
      cyc(3);
      #1;
      `CHK({pa_oe, pb_oe}, 2'b00)
      end_sim;
   end
endmodule
